// *** hdl/tcw_map.vh ***
// register offsets, mode field positions and reset values for the timer channel
`ifndef TCW_MAP_VH
`define TCW_MAP_VH

// register byte offsets
`define TCW_MODE_OFS 8'h00
`define TCW_CTRL_OFS 8'h04
`define TCW_CMPA_OFS 8'h08
`define TCW_CMPB_OFS 8'h0c
`define TCW_CMPC_OFS 8'h10
`define TCW_COUNT_OFS 8'h14
`define TCW_STAT_OFS 8'h18

// reset values
`define TCW_MODE_RST 32'h0000_0000
`define TCW_CMP_RST 32'h0000_0000

// channel_mode_output field lsb positions
`define TCW_CLKS_LSB 0
`define TCW_EDGE_INVERT_BIT 3
`define TCW_GATE_LSB 4
`define TCW_CSTOP_BIT 6
`define TCW_CDIS_BIT 7
`define TCW_EVEDG_LSB 8
`define TCW_EVSRC_LSB 10
`define TCW_EVTRG_BIT 12
`define TCW_PROF_LSB 13
`define TCW_WAVE_BIT 15
`define TCW_A_MATCH_ACTION_LINE_A_LSB 16
`define TCW_C_MATCH_ACTION_LINE_A_LSB 18
`define TCW_AEEV_LSB 20
`define TCW_ASWT_LSB 22
`define TCW_B_MATCH_ACTION_LINE_B_LSB 24
`define TCW_C_MATCH_ACTION_LINE_B_LSB 26
`define TCW_BEEV_LSB 28
`define TCW_BSWT_LSB 30

// control register bits (write one to act)
`define TCW_CTRL_EN_BIT 0
`define TCW_CTRL_DIS_BIT 1
`define TCW_CTRL_SWT_BIT 2

// status register bits
`define TCW_STAT_RUN_BIT 0
`define TCW_STAT_LA_BIT 1
`define TCW_STAT_LB_BIT 2
`define TCW_STAT_DIR_BIT 3

// edge selection codes
`define TCW_EDGE_NONE 2'b00
`define TCW_EDGE_RISE 2'b01
`define TCW_EDGE_FALL 2'b10
`define TCW_EDGE_BOTH 2'b11

// line action codes
`define TCW_ACT_NONE 2'b00
`define TCW_ACT_SET 2'b01
`define TCW_ACT_CLR 2'b10
`define TCW_ACT_TGL 2'b11

`endif

// *** hdl/tcw_edge.v ***
// edge detector with selectable edge polarity
`timescale 1ns/10ps
`include "tcw_map.vh"
module tcw_edge (
  input wire pclk,
  input wire presetn,
  input wire sig,
  input wire [1:0] edge_sel,
  output reg pulse
);
  reg prev;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'b0;
    end else begin
      prev <= sig;
    end
  end

  always @* begin
    case (edge_sel)
      `TCW_EDGE_RISE: pulse = sig & ~prev;
      `TCW_EDGE_FALL: pulse = ~sig & prev;
      `TCW_EDGE_BOTH: pulse = sig ^ prev;
      default: pulse = 1'b0;
    endcase
  end
endmodule

// *** hdl/tcw_action.v ***
// applies a none/set/clear/toggle action to an output line level
`timescale 1ns/10ps
`include "tcw_map.vh"
module tcw_action (
  input wire cur,
  input wire hit,
  input wire [1:0] code,
  output reg nxt
);
  always @* begin
    nxt = cur;
    if (hit) begin
      case (code)
        `TCW_ACT_SET: nxt = 1'b1;
        `TCW_ACT_CLR: nxt = 1'b0;
        `TCW_ACT_TGL: nxt = ~cur;
        default: nxt = cur;
      endcase
    end
  end
endmodule

// *** hdl/tcw_channel.v ***
// timer channel in waveform mode with apb register access
// Contract
// - three-bit source picks internal clocks 1-5 or external clocks 0-2
// - edge invert clear counts on rising edge, set counts on falling edge
// - gate field 00 ungated, else selected clock ANDed with external clock 0-2
// - stop-on-C-match bit stops counter clock when counter reaches compare C
// - disable-on-C-match bit disables counter clock when counter reaches compare C
// - event edge field picks none, rising, falling or both edges
// - event source picks line B or external clock 0-2; B output otherwise
// - line B as event source becomes input and stops its waveform
// - trigger enable clear: event only acts on line A
// - trigger enable set: event resets counter and lifts a C-match stop of its clock; a disabled clock stays disabled
// - profile field selects up or up/down, with or without C-match trigger
// - mode bit zero capture, one waveform; output fields apply only when one
// - compare A match applies its none/set/clear/toggle action to line A
// - compare C match applies its action to line A
// - detected external event applies its action to line A
// - software trigger applies its action to line A
// - compare B match applies its action to line B
// - compare C match applies its action to line B
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "tcw_map.vh"
module tcw_channel #(
  parameter CW = 16,
  parameter AW = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire internal_clock_1,
  input wire internal_clock_2,
  input wire internal_clock_3,
  input wire internal_clock_4,
  input wire internal_clock_5,
  input wire ext_clock_0,
  input wire ext_clock_1,
  input wire ext_clock_2,
  output reg line_a_out,
  output reg line_a_oe,
  input wire line_b_in,
  output reg line_b_out,
  output reg line_b_oe
);
  reg [31:0] mode;
  reg [CW-1:0] comp_a;
  reg [CW-1:0] comp_b;
  reg [CW-1:0] comp_c;
  reg [CW-1:0] count;
  reg dir;
  reg clk_en;
  reg clk_stop;
  reg [CW-1:0] next_count;
  reg next_dir;
  reg [31:0] rd_data;
  reg rd_hit;
  reg sel_clk;
  reg gate_sig;
  reg ev_sig;
  reg [1:0] code_a;
  reg [1:0] code_b;
  // compares are narrower than the bus word, so only the low bits of the reset value apply
  localparam [31:0] CMP_RST = `TCW_CMP_RST;

  wire [2:0] clock_source_select = mode[`TCW_CLKS_LSB +: 3];
  wire edge_invert = mode[`TCW_EDGE_INVERT_BIT];
  wire [1:0] gate_select = mode[`TCW_GATE_LSB +: 2];
  wire stop_on_c_match = mode[`TCW_CSTOP_BIT];
  wire disable_on_c_match = mode[`TCW_CDIS_BIT];
  wire [1:0] event_edge_select = mode[`TCW_EVEDG_LSB +: 2];
  wire [1:0] event_source_select = mode[`TCW_EVSRC_LSB +: 2];
  wire event_trigger_enable = mode[`TCW_EVTRG_BIT];
  wire [1:0] count_profile_select = mode[`TCW_PROF_LSB +: 2];
  wire wave = mode[`TCW_WAVE_BIT];
  wire [1:0] a_match_action_line_a = mode[`TCW_A_MATCH_ACTION_LINE_A_LSB +: 2];
  wire [1:0] c_match_action_line_a = mode[`TCW_C_MATCH_ACTION_LINE_A_LSB +: 2];
  wire [1:0] event_action_line_a = mode[`TCW_AEEV_LSB +: 2];
  wire [1:0] soft_trigger_action_line_a = mode[`TCW_ASWT_LSB +: 2];
  wire [1:0] b_match_action_line_b = mode[`TCW_B_MATCH_ACTION_LINE_B_LSB +: 2];
  wire [1:0] c_match_action_line_b = mode[`TCW_C_MATCH_ACTION_LINE_B_LSB +: 2];
  wire [1:0] event_action_line_b = mode[`TCW_BEEV_LSB +: 2];
  wire [1:0] soft_trigger_action_line_b = mode[`TCW_BSWT_LSB +: 2];

  wire auto_trig = count_profile_select[1];
  wire up_down = count_profile_select[0];
  wire b_is_input = (event_source_select == 2'b00);
  wire [CW-1:0] zero = {CW{1'b0}};
  wire [CW-1:0] one = {{(CW-1){1'b0}}, 1'b1};
  wire [CW-1:0] top = auto_trig ? comp_c : {CW{1'b1}};

  // apb: one wait state, so read data and pready leave flops together
  wire setup_acc = psel & penable & ~pready;
  wire acc = psel & penable & pready;
  // aliases above the low address byte are refused, writes as well as reads
  wire hi_addr = |(paddr >> 8);
  wire wr = acc & pwrite & ~hi_addr;
  wire [7:0] addr = paddr[7:0];
  wire wr_mode = wr & (addr == `TCW_MODE_OFS);
  wire wr_ctrl = wr & (addr == `TCW_CTRL_OFS);
  wire sw_trig = wr_ctrl & pwdata[`TCW_CTRL_SWT_BIT] & wave;

  // counter clock selection and gating
  always @* begin
    case (clock_source_select)
      3'h0: sel_clk = internal_clock_1;
      3'h1: sel_clk = internal_clock_2;
      3'h2: sel_clk = internal_clock_3;
      3'h3: sel_clk = internal_clock_4;
      3'h4: sel_clk = internal_clock_5;
      3'h5: sel_clk = ext_clock_0;
      3'h6: sel_clk = ext_clock_1;
      default: sel_clk = ext_clock_2;
    endcase
    case (gate_select)
      2'b01: gate_sig = ext_clock_0;
      2'b10: gate_sig = ext_clock_1;
      2'b11: gate_sig = ext_clock_2;
      default: gate_sig = 1'b1;
    endcase
    case (event_source_select)
      2'b01: ev_sig = ext_clock_0;
      2'b10: ev_sig = ext_clock_1;
      2'b11: ev_sig = ext_clock_2;
      default: ev_sig = line_b_in;
    endcase
  end

  wire clk_pulse;
  wire ev_pulse;
  wire [1:0] clk_edge = edge_invert ? `TCW_EDGE_FALL : `TCW_EDGE_RISE;

  tcw_edge u_clk_edge (
    .pclk(pclk),
    .presetn(presetn),
    .sig(sel_clk & gate_sig),
    .edge_sel(clk_edge),
    .pulse(clk_pulse)
  );

  tcw_edge u_ev_edge (
    .pclk(pclk),
    .presetn(presetn),
    .sig(ev_sig),
    .edge_sel(event_edge_select),
    .pulse(ev_pulse)
  );

  // capture mode is not built here: in that mode the channel just holds
  wire ev_hit = ev_pulse & wave;
  wire ev_hit_b = ev_hit & event_trigger_enable;
  wire trig = sw_trig | (ev_hit & event_trigger_enable);
  wire tick = wave & clk_en & ~clk_stop & clk_pulse;

  always @* begin
    next_count = count;
    next_dir = dir;
    if (trig) begin
      next_count = zero;
      next_dir = 1'b0;
    end else if (tick) begin
      if (up_down) begin
        if (!dir) begin
          if (count >= top) begin
            next_dir = 1'b1;
            next_count = (count == zero) ? zero : count - one;
          end else begin
            next_count = count + one;
          end
        end else begin
          if (count == zero) begin
            next_dir = 1'b0;
            next_count = (top == zero) ? zero : one;
          end else begin
            next_count = count - one;
          end
        end
      end else if (auto_trig && count == comp_c) begin
        next_count = zero;
      end else begin
        next_count = count + one;
      end
    end
  end

  // a compare match is the tick at which the counter arrives at the value
  wire moved = tick & ~trig;
  wire a_match = moved & (next_count == comp_a);
  wire b_match = moved & (next_count == comp_b);
  wire c_match = moved & (next_count == comp_c);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {CW{1'b0}};
      dir <= 1'b0;
    end else begin
      count <= next_count;
      dir <= next_dir;
    end
  end

  // clock state: disable needs a software enable, stop is lifted by a trigger
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en <= 1'b0;
      clk_stop <= 1'b0;
    end else begin
      if (wr_ctrl && pwdata[`TCW_CTRL_DIS_BIT]) begin
        clk_en <= 1'b0;
      end else if (c_match && disable_on_c_match) begin
        clk_en <= 1'b0;
      end else if (wr_ctrl && pwdata[`TCW_CTRL_EN_BIT]) begin
        clk_en <= 1'b1;
      end
      if (c_match && stop_on_c_match) begin
        clk_stop <= 1'b1;
      end else if (trig || (wr_ctrl && pwdata[`TCW_CTRL_EN_BIT])) begin
        clk_stop <= 1'b0;
      end
    end
  end

  // simultaneous events: software trigger over event over C over A/B
  always @* begin
    code_a = a_match_action_line_a;
    code_b = b_match_action_line_b;
    if (c_match) begin
      code_a = c_match_action_line_a;
      code_b = c_match_action_line_b;
    end
    if (ev_hit_b) begin
      code_b = event_action_line_b;
    end
    if (ev_hit) begin
      code_a = event_action_line_a;
    end
    if (sw_trig) begin
      code_a = soft_trigger_action_line_a;
      code_b = soft_trigger_action_line_b;
    end
  end

  wire hit_a = wave & (sw_trig | ev_hit | c_match | a_match);
  wire hit_b = wave & ~b_is_input & (sw_trig | ev_hit_b | c_match | b_match);
  wire next_la;
  wire next_lb;

  tcw_action u_act_a (
    .cur(line_a_out),
    .hit(hit_a),
    .code(code_a),
    .nxt(next_la)
  );

  tcw_action u_act_b (
    .cur(line_b_out),
    .hit(hit_b),
    .code(code_b),
    .nxt(next_lb)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_a_out <= 1'b0;
      line_b_out <= 1'b0;
      line_a_oe <= 1'b0;
      line_b_oe <= 1'b0;
    end else begin
      line_a_out <= next_la;
      line_b_out <= next_lb;
      line_a_oe <= wave;
      line_b_oe <= wave & ~b_is_input;
    end
  end

  // register writes take effect at the access edge where pready is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `TCW_MODE_RST;
      comp_a <= CMP_RST[CW-1:0];
      comp_b <= CMP_RST[CW-1:0];
      comp_c <= CMP_RST[CW-1:0];
    end else if (wr) begin
      if (wr_mode) begin
        mode <= pwdata;
      end else if (addr == `TCW_CMPA_OFS) begin
        comp_a <= pwdata[CW-1:0];
      end else if (addr == `TCW_CMPB_OFS) begin
        comp_b <= pwdata[CW-1:0];
      end else if (addr == `TCW_CMPC_OFS) begin
        comp_c <= pwdata[CW-1:0];
      end
    end
  end

  always @* begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    if (addr == `TCW_MODE_OFS) begin
      rd_data = mode;
    end else if (addr == `TCW_CTRL_OFS) begin
      rd_data = 32'h0000_0000;
    end else if (addr == `TCW_CMPA_OFS) begin
      rd_data = {{(32-CW){1'b0}}, comp_a};
    end else if (addr == `TCW_CMPB_OFS) begin
      rd_data = {{(32-CW){1'b0}}, comp_b};
    end else if (addr == `TCW_CMPC_OFS) begin
      rd_data = {{(32-CW){1'b0}}, comp_c};
    end else if (addr == `TCW_COUNT_OFS) begin
      rd_data = {{(32-CW){1'b0}}, count};
    end else if (addr == `TCW_STAT_OFS) begin
      rd_data[`TCW_STAT_RUN_BIT] = clk_en & ~clk_stop;
      rd_data[`TCW_STAT_LA_BIT] = line_a_out;
      rd_data[`TCW_STAT_LB_BIT] = b_is_input ? line_b_in : line_b_out;
      rd_data[`TCW_STAT_DIR_BIT] = dir;
    end else begin
      rd_hit = 1'b0;
    end
    if (hi_addr) begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_acc;
      pslverr <= setup_acc & ~rd_hit;
      if (setup_acc && !pwrite && rd_hit) begin
        prdata <= rd_data;
      end else if (setup_acc) begin
        prdata <= 32'h0000_0000;
      end
    end
  end
endmodule

// *** verification/tcw_partner.sv ***
// far-side model: clock sources and the line b pad
`timescale 1ns/10ps
module tcw_partner (
  input wire pclk,
  input wire line_b_out,
  input wire line_b_oe,
  output logic [4:0] int_clk,
  output logic [2:0] ext_clk,
  output wire line_b_in
);
  logic [5:0] div = 6'h00;
  initial ext_clk = 3'h0;
  always @(posedge pclk) div <= div + 6'h01;
  assign int_clk = div[5:1];
  // a released pad shows div[0], toggling every pclk, not a held copy of the last driven level
  assign line_b_in = line_b_oe ? line_b_out : div[0];
  // each level lasts two pclk so the sampler never misses an edge
  task automatic edges(input int i, input int n);
    repeat (n) begin
      @(posedge pclk);
      ext_clk[i] <= 1'b1;
      repeat (2) @(posedge pclk);
      ext_clk[i] <= 1'b0;
      @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
  endtask
endmodule

// *** verification/tcw_chk.sv ***
// concurrent checks on the timer channel ports
`timescale 1ns/10ps
module tcw_chk #(
  parameter CW = 16,
  parameter AW = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire line_a_out,
  input wire line_a_oe,
  input wire line_b_out,
  input wire line_b_oe
);
  reg wave_q;
  reg b_in_q;
  reg [1:0] age;
  wire mode_wr = psel && penable && pready && pwrite && paddr == {AW{1'b0}};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // age lets registered outputs settle after a mode write before judging them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_q <= 1'b0;
      b_in_q <= 1'b1;
      age <= 2'd0;
    end else if (mode_wr) begin
      wave_q <= pwdata[15];
      b_in_q <= pwdata[11:10] == 2'b00;
      age <= 2'd0;
    end else if (age != 2'd3) begin
      age <= age + 2'd1;
    end
  end
  sequence access_s;
    psel && penable && !pready;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  wait_state_a: assert property (access_s |=> answer_s)
    else $error("no single-cycle answer");
  resp_cause_a: assert property ($rose(pready) |-> $past(psel && penable))
    else $error("answer without request");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  err_pulse_a: assert property (pslverr |=> !pslverr)
    else $error("error answer too long");
  a_enable_a: assert property (age == 2'd3 |-> line_a_oe == wave_q)
    else $error("line a enable wrong");
  b_enable_a: assert property (age == 2'd3 |-> line_b_oe == (wave_q && !b_in_q))
    else $error("line b enable wrong");
  capture_idle_a: assert property (age == 2'd3 && !wave_q |->
    $stable(line_a_out) && $stable(line_b_out))
    else $error("lines move in capture mode");
  b_frozen_a: assert property (age == 2'd3 && b_in_q |-> $stable(line_b_out))
    else $error("line b moves while input");
endmodule
bind tcw_channel tcw_chk #(.CW(CW), .AW(AW)) tcw_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .line_a_out(line_a_out),
  .line_a_oe(line_a_oe), .line_b_out(line_b_out), .line_b_oe(line_b_oe)
);

// *** verification/tcw_channel_bench.sv ***
// self-checking bench for the timer channel
`timescale 1ns/10ps
module tcw_channel_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic rerr, la, la_oe, lb, lb_oe, lb_in;
  logic [4:0] ic;
  logic [2:0] xc;
  int num_errors = 0;
  int checked = 0;
  tcw_channel #(.CW(16), .AW(8)) tcw_channel_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .internal_clock_1(ic[0]), .internal_clock_2(ic[1]), .internal_clock_3(ic[2]),
    .internal_clock_4(ic[3]), .internal_clock_5(ic[4]),
    .ext_clock_0(xc[0]), .ext_clock_1(xc[1]), .ext_clock_2(xc[2]),
    .line_a_out(la), .line_a_oe(la_oe), .line_b_in(lb_in),
    .line_b_out(lb), .line_b_oe(lb_oe)
  );
  tcw_partner tcw_partner_i (
    .pclk(pclk), .line_b_out(lb), .line_b_oe(lb_oe),
    .int_clk(ic), .ext_clk(xc), .line_b_in(lb_in)
  );
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic test_done();
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 16) begin
      num_errors++;
      $display("unexpected at %0t: no pready", $time);
      test_done();
    end
  endtask
  task automatic t_regs();
    apb(1'b0, 8'h00, 32'h0);
    cmp(rdata, 32'h0);
    apb(1'b1, 8'h00, 32'ha5a5_0f0f);
    apb(1'b0, 8'h00, 32'h0);
    cmp(rdata, 32'ha5a5_0f0f);
    cmp({31'h0, la_oe}, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    cmp(rdata, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    cmp({rdata[30:0], rerr}, 32'h1);
  endtask
  // ext clock 0 drives the count; A sets line a, C clears it and stops
  task automatic t_count();
    apb(1'b1, 8'h08, 32'h3);
    apb(1'b1, 8'h10, 32'h6);
    apb(1'b1, 8'h00, 32'h0009_8045);
    apb(1'b1, 8'h04, 32'h1);
    cmp({30'h0, la_oe, lb_oe}, 32'h2);
    tcw_partner_i.edges(0, 4);
    apb(1'b0, 8'h14, 32'h0);
    cmp(rdata, 32'h4);
    cmp({31'h0, la}, 32'h1);
    tcw_partner_i.edges(0, 4);
    apb(1'b0, 8'h14, 32'h0);
    cmp(rdata, 32'h6);
    cmp({31'h0, la}, 32'h0);
  endtask
  // rising edges of ext clock 1 toggle line a; counter stays put
  task automatic t_event();
    apb(1'b1, 8'h00, 32'h1070_8900);
    @(posedge pclk);
    cmp({31'h0, lb_oe}, 32'h1);
    tcw_partner_i.edges(1, 1);
    cmp({31'h0, la}, 32'h1);
    tcw_partner_i.edges(1, 1);
    cmp({31'h0, la}, 32'h0);
    cmp({31'h0, lb}, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    cmp(rdata, 32'h6);
    apb(1'b1, 8'h04, 32'h4);
    repeat (2) @(posedge pclk);
    cmp({31'h0, la}, 32'h1);
  endtask
  // falling ext clock 2 edges count up/down with C trigger; B set at B, cleared at C
  task automatic t_wave();
    apb(1'b1, 8'h04, 32'h2);
    apb(1'b1, 8'h0c, 32'h2);
    apb(1'b1, 8'h10, 32'h3);
    apb(1'b1, 8'h00, 32'h090c_e40f);
    apb(1'b1, 8'h04, 32'h5);
    tcw_partner_i.edges(2, 2);
    apb(1'b0, 8'h14, 32'h0);
    cmp(rdata, 32'h2);
    cmp({31'h0, lb}, 32'h1);
    tcw_partner_i.edges(2, 1);
    cmp({30'h0, la, lb}, 32'h0);
    tcw_partner_i.edges(2, 1);
    apb(1'b0, 8'h18, 32'h0);
    cmp(rdata, 32'hd);
    tcw_partner_i.edges(2, 3);
    apb(1'b0, 8'h14, 32'h0);
    cmp(rdata, 32'h1);
    // gated by ext clock 1, which stays low, so nothing counts
    apb(1'b1, 8'h00, 32'h090c_e42f);
    tcw_partner_i.edges(2, 2);
    apb(1'b0, 8'h14, 32'h0);
    cmp(rdata, 32'h1);
  endtask
  // rising ext clock 2 edges wrap at C, then C disables; ext clock 0 triggers
  task automatic t_trig();
    apb(1'b1, 8'h00, 32'h2000_d507);
    tcw_partner_i.edges(2, 3);
    apb(1'b0, 8'h14, 32'h0);
    cmp(rdata, 32'h0);
    apb(1'b1, 8'h00, 32'h2000_d587);
    tcw_partner_i.edges(2, 4);
    apb(1'b0, 8'h14, 32'h0);
    cmp(rdata, 32'h3);
    tcw_partner_i.edges(0, 1);
    apb(1'b0, 8'h14, 32'h0);
    cmp(rdata, 32'h0);
    cmp({31'h0, lb}, 32'h0);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_count();
    t_event();
    t_wave();
    t_trig();
    test_done();
  end
endmodule
